// ### verilog/hub_port_pkg.sv
package hub_port_pkg;
  localparam logic [6:0] CMD_ADDR      = 7'h1B;
  localparam logic [6:0] DATA_ADDR     = 7'h1A;
  localparam logic [7:0] CMD_RESET_VAL = 8'h00;
  // command codes and groups
  localparam logic [7:0] CMD_SEL_EP    = 8'h00;
  localparam logic [7:0] CMD_LAST_STAT = 8'h40;
  localparam logic [7:0] CMD_EP_STAT   = 8'h80;
  localparam logic [7:0] CMD_SET_ADDR  = 8'hD0;
  localparam logic [7:0] CMD_EP_ENABLE = 8'hD8;
  localparam logic [7:0] CMD_CLR_PORT  = 8'hE0;
  localparam logic [7:0] CMD_SET_PORT  = 8'hE8;
  localparam logic [7:0] CMD_BUFFER    = 8'hF0;
  localparam logic [7:0] CMD_ACK_SETUP = 8'hF1;
  localparam logic [7:0] CMD_CLR_BUF   = 8'hF2;
  localparam logic [7:0] CMD_SET_MODE  = 8'hF3;
  localparam logic [7:0] CMD_READ_INT  = 8'hF4;
  localparam logic [7:0] CMD_FRAME     = 8'hF5;
  localparam logic [7:0] CMD_RESUME    = 8'hF6;
  localparam logic [7:0] CMD_STAT_CHG  = 8'hF7;
  localparam logic [7:0] CMD_VALID_BUF = 8'hFA;
  localparam logic [7:0] EP_INDEX_MAX  = 8'h0D;
  // timing: a 1MHz serial clock gives 500 ns halves
  localparam int SCL_HALF_NS   = 500;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCL_HALF_CYC  = SCL_HALF_NS / CLK_PERIOD_NS;
  // decoded operation for the mmu
  typedef enum logic [3:0] {
    OP_NONE      = 4'h0, OP_SET_ADDR  = 4'h1, OP_EP_ENABLE = 4'h2,
    OP_SET_MODE  = 4'h3, OP_READ_INT  = 4'h4, OP_SEL_EP    = 4'h5,
    OP_LAST_STAT = 4'h6, OP_EP_STAT   = 4'h7, OP_BUFFER    = 4'h8,
    OP_ACK_SETUP = 4'h9, OP_CLR_BUF   = 4'hA, OP_VALID_BUF = 4'hB,
    OP_CLR_PORT  = 4'hC, OP_SET_PORT  = 4'hD, OP_STAT_CHG  = 4'hE,
    OP_RESUME    = 4'hF
  } op_type;
  localparam op_type OP_FRAME = OP_READ_INT;
endpackage

// ### verilog/cmd_decode.sv
`timescale 1ns/1ps
// decodes a command byte into an operation and an index
module cmd_decode (
  // command byte
  input  wire logic [7:0]           code,
  // decoded result
  output hub_port_pkg::op_type      op,
  output logic [3:0]                index,
  output logic                      frame
);
  import hub_port_pkg::*;

  // group by high bits; index is low nibble
  always_comb begin
    op    = OP_NONE;
    index = code[3:0];
    frame = 1'b0;
    if ((code & 8'hC0) == CMD_SEL_EP && (code & 8'h3F) <= EP_INDEX_MAX) begin
      op = OP_SEL_EP;
    end else if ((code & 8'hC0) == CMD_LAST_STAT
                 && (code & 8'h3F) <= EP_INDEX_MAX) begin
      op = OP_LAST_STAT;
    end else if ((code & 8'hC0) == CMD_EP_STAT
                 && (code & 8'h3F) <= EP_INDEX_MAX) begin
      op = OP_EP_STAT;
    end else if ((code & 8'hFC) == CMD_SET_ADDR) begin
      op = OP_SET_ADDR;
    end else if (code == CMD_EP_ENABLE) begin
      op = OP_EP_ENABLE;
    end else if ((code & 8'hFC) == CMD_CLR_PORT) begin
      op = OP_CLR_PORT;
    end else if ((code & 8'hFC) == CMD_SET_PORT) begin
      op = OP_SET_PORT;
    end else begin
      case (code)
        CMD_BUFFER:    op = OP_BUFFER;
        CMD_ACK_SETUP: op = OP_ACK_SETUP;
        CMD_CLR_BUF:   op = OP_CLR_BUF;
        CMD_VALID_BUF: op = OP_VALID_BUF;
        CMD_SET_MODE:  op = OP_SET_MODE;
        CMD_READ_INT:  op = OP_READ_INT;
        CMD_STAT_CHG:  op = OP_STAT_CHG;
        CMD_RESUME:    op = OP_RESUME;
        CMD_FRAME: begin
          op    = OP_FRAME;
          frame = 1'b1;
        end
        default:       op = OP_NONE;
      endcase
    end
  end
endmodule

// ### verilog/hub_serial_port.sv
`timescale 1ns/1ps
// serial slave port: samples scl/sda on clk, decodes addresses and
// commands, and hands bytes to the memory manager
module hub_serial_port (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // serial pins, open drain
  input  wire logic                 scl_in,
  input  wire logic                 sda_in,
  output logic                      sda_out,
  output logic                      sda_oe,
  // interrupt pin, open drain
  input  wire logic                 irq_req,
  output logic                      int_n_out,
  output logic                      int_n_oe,
  // command stream to memory manager
  output logic                      cmd_valid,
  output logic [7:0]                cmd_byte,
  output hub_port_pkg::op_type      cmd_op,
  output logic [3:0]                cmd_index,
  // data write stream
  output logic                      wr_valid,
  output logic [7:0]                wr_byte,
  output logic [1:0]                wr_count,
  // data read stream
  output logic                      rd_req,
  output logic [1:0]                rd_count,
  input  wire logic [7:0]           rd_byte,
  // decoded operation held for the data phase
  output hub_port_pkg::op_type      cur_op,
  output logic [3:0]                cur_index,
  output logic                      cur_read,
  output logic                      busy
);
  import hub_port_pkg::*;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_ADDR = 6'b000010,
    ST_AACK = 6'b000100,
    ST_RXD  = 6'b001000,
    ST_TXD  = 6'b010000,
    ST_TACK = 6'b100000
  } st_type;

  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic       scl_d;
    logic       sda_d;
    st_type     st;
    logic [7:0] shift;
    logic [3:0] bits;
    logic       is_cmd;
    logic       rw;
    logic       drive;
    logic       ack_pend;
    logic [7:0] cmd;
    op_type     op;
    logic [3:0] idx;
    logic       cmd_v;
    logic       wr_v;
    logic [7:0] wr_b;
    logic [1:0] wr_n;
    logic       rd_r;
    logic [1:0] rd_n;
    logic       irq_s0;
    logic       irq_s1;
    logic       int_oe;
    logic       active;
  } state_type;

  state_type state_reg;
  state_type state_next;
  op_type    dec_op;
  logic [3:0] dec_idx;

  cmd_decode u_dec (
    .code  (state_reg.shift),
    .op    (dec_op),
    .index (dec_idx),
    .frame ()
  );

  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;

  // edges taken from the second sync stage only; at 100 MHz a 1MHz
  // serial clock gives many samples per half period
  assign scl      = state_reg.scl_sync[1];
  assign sda      = state_reg.sda_sync[1];
  assign scl_rise = scl & ~state_reg.scl_d;
  assign scl_fall = ~scl & state_reg.scl_d;
  assign start_c  = scl & state_reg.scl_d & ~sda & state_reg.sda_d;
  assign stop_c   = scl & state_reg.scl_d & sda & ~state_reg.sda_d;

  // one next-state process for the whole port
  always_comb begin
    state_next = state_reg;
    state_next.scl_sync = {state_reg.scl_sync[0], scl_in};
    state_next.sda_sync = {state_reg.sda_sync[0], sda_in};
    state_next.scl_d = scl;
    state_next.sda_d = sda;
    state_next.cmd_v = 1'b0;
    state_next.wr_v  = 1'b0;
    state_next.rd_r  = 1'b0;
    // interrupt request is a level from outside: synchronise it
    state_next.irq_s0 = irq_req;
    state_next.irq_s1 = state_reg.irq_s0;
    state_next.int_oe = state_reg.irq_s1;
    if (start_c) begin
      // start or repeated start opens a new address phase
      state_next.st    = ST_ADDR;
      state_next.bits  = 4'h0;
      state_next.drive = 1'b0;
    end else if (stop_c) begin
      state_next.st    = ST_IDLE;
      state_next.drive = 1'b0;
    end else begin
      case (state_reg.st)
        ST_IDLE: begin
          state_next.drive = 1'b0;
        end
        ST_ADDR: begin
          if (scl_rise) begin
            state_next.shift = {state_reg.shift[6:0], sda};
            state_next.bits  = state_reg.bits + 4'h1;
          end else if (scl_fall && state_reg.bits == 4'h8) begin
            state_next.rw     = state_reg.shift[0];
            state_next.is_cmd = state_reg.shift[7:1] == CMD_ADDR;
            if (state_reg.shift[7:1] == CMD_ADDR && !state_reg.shift[0])
            begin
              state_next.drive = 1'b1;
              state_next.st    = ST_AACK;
            end else if (state_reg.shift[7:1] == DATA_ADDR) begin
              state_next.drive    = 1'b1;
              state_next.st       = ST_AACK;
              state_next.wr_n     = 2'd0;
              state_next.rd_n     = 2'd0;
              state_next.ack_pend = 1'b0;
            end else begin
              // command read or foreign address: stay off the bus
              state_next.st = ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            state_next.bits = 4'h0;
            if (!state_reg.is_cmd && state_reg.rw) begin
              state_next.rd_r  = 1'b1;
              state_next.st    = ST_TXD;
              state_next.drive = 1'b0;
            end else begin
              state_next.drive = 1'b0;
              state_next.st    = ST_RXD;
            end
          end
        end
        ST_RXD: begin
          if (scl_rise) begin
            state_next.shift = {state_reg.shift[6:0], sda};
            state_next.bits  = state_reg.bits + 4'h1;
          end else if (scl_fall && state_reg.bits == 4'h8) begin
            state_next.drive = 1'b1;
            state_next.st    = ST_AACK;
            if (state_reg.is_cmd) begin
              // each byte is a new command; data phase restarts
              state_next.cmd   = state_reg.shift;
              state_next.op    = dec_op;
              state_next.idx   = dec_idx;
              state_next.cmd_v = 1'b1;
              state_next.wr_n  = 2'd0;
              state_next.rd_n  = 2'd0;
            end else begin
              state_next.wr_b = state_reg.shift;
              state_next.wr_v = 1'b1;
              if (state_reg.wr_n != 2'd3) begin
                state_next.wr_n = state_reg.wr_n + 2'd1;
              end
            end
          end
        end
        ST_TXD: begin
          // bits shift out msb first, changed only while scl is low
          if (state_reg.bits == 4'h0 && !scl && !state_reg.ack_pend) begin
            state_next.shift    = rd_byte;
            state_next.ack_pend = 1'b1;
            state_next.drive    = ~rd_byte[7];
          end else if (scl_fall) begin
            if (state_reg.bits == 4'h7) begin
              state_next.drive = 1'b0;
              state_next.bits  = 4'h0;
              state_next.st    = ST_TACK;
            end else begin
              state_next.bits  = state_reg.bits + 4'h1;
              state_next.drive = ~state_reg.shift[6];
              state_next.shift = {state_reg.shift[6:0], 1'b0};
            end
          end
        end
        ST_TACK: begin
          state_next.drive = 1'b0;
          if (scl_rise) begin
            state_next.ack_pend = 1'b0;
            if (sda) begin
              // master refused: release and wait for stop
              state_next.st = ST_IDLE;
            end else begin
              state_next.st   = ST_TXD;
              state_next.rd_r = 1'b1;
              if (state_reg.rd_n != 2'd3) begin
                state_next.rd_n = state_reg.rd_n + 2'd1;
              end
            end
          end
        end
        default: begin
          state_next.st = ST_IDLE;
        end
      endcase
    end
    // busy gets a flop of its own so the pin never shows decode glitches
    state_next.active = state_next.st != ST_IDLE;
  end

  // single state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= '{scl_sync: 2'b11, sda_sync: 2'b11, scl_d: 1'b1,
                     sda_d: 1'b1, st: ST_IDLE, shift: 8'h00,
                     bits: 4'h0, is_cmd: 1'b0, rw: 1'b0, drive: 1'b0,
                     ack_pend: 1'b0, cmd: CMD_RESET_VAL, op: OP_NONE,
                     idx: 4'h0, cmd_v: 1'b0, wr_v: 1'b0, wr_b: 8'h00,
                     wr_n: 2'd0, rd_r: 1'b0, rd_n: 2'd0, irq_s0: 1'b0,
                     irq_s1: 1'b0, int_oe: 1'b0, active: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from the state register, with sda_out and int_n_out tied low
  assign sda_out   = 1'b0;
  assign sda_oe    = state_reg.drive;
  assign int_n_out = 1'b0;
  assign int_n_oe  = state_reg.int_oe;
  assign cmd_valid = state_reg.cmd_v;
  assign cmd_byte  = state_reg.cmd;
  assign cmd_op    = state_reg.op;
  assign cmd_index = state_reg.idx;
  assign wr_valid  = state_reg.wr_v;
  assign wr_byte   = state_reg.wr_b;
  assign wr_count  = state_reg.wr_n;
  assign rd_req    = state_reg.rd_r;
  assign rd_count  = state_reg.rd_n;
  assign cur_op    = state_reg.op;
  assign cur_index = state_reg.idx;
  assign cur_read  = state_reg.rw;
  assign busy      = state_reg.active;
endmodule

// ### dv/ctrl_master.sv
`timescale 1ns/1ps
// microcontroller stand-in; sda is only pulled low and its pull-up does the rest, scl is driven both ways
module ctrl_master (
  // serial lines
  output logic      scl_line,
  output logic      sda_pull,
  input  wire logic sda_line
);
  localparam int QTR = 40; // 160 ns bit, faster than 1MHz
  // idle bus: both lines released
  initial begin
    scl_line = 1'b1;
    sda_pull = 1'b0;
  end
  // one bit: data moves mid-low, is sampled mid-high
  task automatic clk_bit(input logic v, output logic s);
    #QTR sda_pull = !v;
    #QTR scl_line = 1'b1;
    #QTR s = sda_line;
    #QTR scl_line = 1'b0;
  endtask
  // start or repeated start: sda falls while scl is high
  task automatic start();
    #QTR sda_pull = 1'b0;
    #QTR scl_line = 1'b1;
    #QTR sda_pull = 1'b1;
    #QTR scl_line = 1'b0;
  endtask
  // stop: sda rises while scl is high
  task automatic stop();
    #QTR sda_pull = 1'b1;
    #QTR scl_line = 1'b1;
    #QTR sda_pull = 1'b0;
    #QTR;
  endtask
  // byte out msb first, ack read in the ninth bit
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
    clk_bit(1'b1, s);
    ack = !s;
  endtask
  // byte in; only the last one is left unacknowledged
  task automatic get_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, s);
      b[i] = s;
    end
    clk_bit(last, s);
  endtask
endmodule

// ### dv/hub_port_monitor.sv
`timescale 1ns/1ps
// watches the serial port's pins and strobes for protocol slips
module hub_port_monitor (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // pins
  input wire logic       scl_in,
  input wire logic       irq_req,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       int_n_out,
  input wire logic       int_n_oe,
  // streams
  input wire logic       cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic [3:0] cmd_index,
  input wire logic       wr_valid,
  input wire logic       rd_req,
  input wire logic       cur_read,
  input wire logic       busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // a stream strobe lasts exactly one cycle
  sequence s_pulse(sig);
    sig ##1 !sig;
  endsequence
  property p_cmd_pulse;
    cmd_valid |-> s_pulse(cmd_valid);
  endproperty
  property p_cmd_open;
    cmd_valid |-> busy && !cur_read;
  endproperty
  property p_cmd_index;
    cmd_valid |-> cmd_index == cmd_byte[3:0];
  endproperty
  property p_wr_pulse;
    wr_valid |-> busy && !cur_read ##1 !wr_valid;
  endproperty
  property p_rd_open;
    rd_req |-> busy && cur_read;
  endproperty
  property p_one_stream;
    cmd_valid |-> !wr_valid && !rd_req;
  endproperty
  // sync pipeline of two flops plus the output register
  property p_int_follow;
    int_n_oe == $past(irq_req, 3) && !int_n_out;
  endproperty
  // sda may only move while scl is low
  property p_sda_hold;
    scl_in && $past(scl_in) |-> $stable(sda_oe);
  endproperty
  property p_sda_owned;
    sda_oe |-> !sda_out && (busy || $past(busy));
  endproperty
  a_cmd_pulse: assert property (p_cmd_pulse)
    else $error("command strobe longer than a cycle");
  a_cmd_open: assert property (p_cmd_open)
    else $error("command byte outside a write transaction");
  a_cmd_index: assert property (p_cmd_index)
    else $error("command index not the low nibble");
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("write strobe bad");
  a_rd_open: assert property (p_rd_open)
    else $error("read request outside a read");
  a_one_stream: assert property (p_one_stream)
    else $error("command and data strobes together");
  a_int_follow: assert property (p_int_follow)
    else $error("interrupt pin does not follow request");
  a_sda_hold: assert property (p_sda_hold)
    else $error("sda moved while scl high");
  a_sda_owned: assert property (p_sda_owned)
    else $error("sda pulled outside a transaction");
endmodule
bind hub_serial_port hub_port_monitor u_mon (.clk, .rst, .scl_in, .irq_req,
  .sda_out, .sda_oe, .int_n_out, .int_n_oe, .cmd_valid, .cmd_byte,
  .cmd_index, .wr_valid, .rd_req, .cur_read, .busy);

// ### dv/usb_hub_i2c_command_port_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
  comparisons++; \
  if ((got) !== (ex)) begin \
    errors++; \
    $display("mismatch %s expected %h seen %h", nm, ex, got); \
  end \
end
module usb_hub_i2c_command_port_tb_top;
  import hub_port_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       irq_req = 1'b0;
  logic [7:0] rd_byte = 8'h00;
  logic       m_scl, m_pull, sda_oe, sda_out, int_n_oe, int_n_out;
  logic       cmd_valid, wr_valid, rd_req, cur_read, busy;
  logic [7:0] cmd_byte, wr_byte, b, w0, w1;
  logic [6:0] a;
  logic [3:0] cmd_index, cur_index;
  logic [1:0] wr_count, rd_count;
  op_type     cmd_op, cur_op;
  int         errors = 0, comparisons = 0, seed = 62;
  logic [7:0] rd_tab [4];
  logic [7:0] cq [$];
  logic [3:0] iq [$];
  logic [2:0] irq_q = 3'h0;
  op_type     oq [$];
  logic [9:0] wq [$];
  logic [7:0] codes [$] = '{8'h00, 8'h01, 8'h0D, 8'h0E, 8'h40, 8'h4D,
    8'h80, 8'h81, 8'h8E, 8'hD0, 8'hD3, 8'hD8, 8'hE0, 8'hE3, 8'hE8,
    8'hEB, 8'hEC, 8'hF0, 8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'hF5, 8'hF6,
    8'hF7, 8'hFA, 8'hFF};
  op_type     ftab [11] = '{OP_BUFFER, OP_ACK_SETUP, OP_CLR_BUF,
    OP_SET_MODE, OP_READ_INT, OP_FRAME, OP_RESUME, OP_STAT_CHG, OP_NONE,
    OP_NONE, OP_VALID_BUF};
  // wired-and sda with pull-up
  wire        sda_w = !((sda_oe && !sda_out) || m_pull);

  ctrl_master m (.scl_line(m_scl), .sda_pull(m_pull), .sda_line(sda_w));
  hub_serial_port dut (.clk(clk), .rst(rst), .scl_in(m_scl),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .irq_req(irq_req),
    .int_n_out(int_n_out), .int_n_oe(int_n_oe), .cmd_valid(cmd_valid),
    .cmd_byte(cmd_byte), .cmd_op(cmd_op), .cmd_index(cmd_index),
    .wr_valid(wr_valid), .wr_byte(wr_byte), .wr_count(wr_count),
    .rd_req(rd_req), .rd_count(rd_count), .rd_byte(rd_byte),
    .cur_op(cur_op), .cur_index(cur_index), .cur_read(cur_read),
    .busy(busy));

  always #5 clk = !clk;
  // log every command and write strobe so whole streams can be compared afterwards
  always @(posedge clk) begin
    if (cmd_valid) begin
      cq.push_back(cmd_byte);
      oq.push_back(cmd_op);
      iq.push_back(cmd_index);
    end
    if (wr_valid) wq.push_back({wr_count, wr_byte});
    // pin trails the request: two sync flops, then the output flop
    if (!rst) begin
      `CHK("interrupt pin", irq_q[2], int_n_oe)
      `CHK("interrupt level", 1'b0, int_n_out)
    end
    irq_q <= {irq_q[1:0], irq_req};
  end
  // hub core side: random attention requests, read bytes by read count
  always @(negedge clk) begin
    if (!rst && ($random(seed) % 64) == 0) irq_req <= !irq_req;
    rd_byte <= rd_tab[rd_count];
  end
  // decode expected from the command code groups
  function automatic op_type exp_op(input logic [7:0] c);
    case (c[7:4])
      4'h0: return (c[3:0] <= 4'hD) ? OP_SEL_EP : OP_NONE;
      4'h4: return (c[3:0] <= 4'hD) ? OP_LAST_STAT : OP_NONE;
      4'h8: return (c[3:0] <= 4'hD) ? OP_EP_STAT : OP_NONE;
      4'hD: return (c == 8'hD8) ? OP_EP_ENABLE :
                   (c < 8'hD4) ? OP_SET_ADDR : OP_NONE;
      4'hE: return c[2] ? OP_NONE : (c[3] ? OP_SET_PORT : OP_CLR_PORT);
      4'hF: return (c[3:0] <= 4'hA) ? ftab[c[3:0]] : OP_NONE;
      default: return OP_NONE;
    endcase
  endfunction
  task automatic results();
    if (errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic addr(input logic [6:0] ad, input logic rw, input logic ok);
    logic ack;
    m.start();
    m.put_byte({ad, rw}, ack);
    `CHK("address ack", ok, ack)
  endtask
  task automatic send(input logic [7:0] v);
    logic ack;
    m.put_byte(v, ack);
    `CHK("byte ack", 1'b1, ack)
  endtask
  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    results();
  end
  initial begin
    for (int i = 0; i < 4; i++) rd_tab[i] = 8'($random(seed));
    for (int i = 0; i < 4; i++) codes.push_back(8'($random(seed)));
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    // one long command stream over every code group
    addr(CMD_ADDR, 1'b0, 1'b1);
    foreach (codes[i]) send(codes[i]);
    m.stop();
    `CHK("command count", codes.size(), cq.size())
    foreach (codes[i]) begin
      `CHK("command byte", codes[i], cq[i])
      `CHK("command op", exp_op(codes[i]), oq[i])
      `CHK("command index", codes[i][3:0], iq[i])
    end
    // buffer write via repeated start, bytes numbered per transaction
    w0 = 8'($random(seed));
    w1 = 8'($random(seed));
    addr(CMD_ADDR, 1'b0, 1'b1);
    send(CMD_BUFFER);
    addr(DATA_ADDR, 1'b0, 1'b1);
    send(w0);
    send(w1);
    m.stop();
    // the byte count steps together with the strobe, so it reads one ahead
    `CHK("write 0", {2'h1, w0}, wq[0])
    `CHK("write 1", {2'h2, w1}, wq[1])
    `CHK("write op", OP_BUFFER, cur_op)
    `CHK("write index", CMD_BUFFER[3:0], cur_index)
    // buffer read of three, interrupt status read of two
    for (int k = 0; k < 2; k++) begin
      addr(CMD_ADDR, 1'b0, 1'b1);
      send(k == 0 ? CMD_BUFFER : CMD_READ_INT);
      addr(DATA_ADDR, 1'b1, 1'b1);
      for (int j = 0; j < 3 - k; j++) begin
        m.get_byte(j == 2 - k, b);
        `CHK("read byte", rd_tab[j], b)
      end
      repeat (5) @(negedge clk);
      `CHK("released", 1'b0, sda_oe)
      `CHK("read dir", 1'b1, cur_read)
      `CHK("read op", k == 0 ? OP_BUFFER : OP_READ_INT, cur_op)
      m.stop();
    end
    // refused: read at command address, then foreign addresses
    addr(CMD_ADDR, 1'b1, 1'b0);
    m.stop();
    for (int k = 0; k < 4; k++) begin
      a = 7'($random(seed));
      if (a[6:1] == 6'h0D) a = a ^ 7'h40;
      addr(a, k[0], 1'b0);
      `CHK("idle", 1'b0, busy)
      m.stop();
    end
    results();
  end
endmodule
